// ==== hw/dsm_carrier.sv ====
// Purpose: carrier selection, inversion, pin disable and switch sync
// Assumes: pin inputs are asynchronous and pass two flip-flops first
// Notes: registers sit on APB with zero wait states
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////
// What this block does
// - High pin-disable bit set stops the high carrier source driving its pin.
// - High polarity bit inverts the selected high carrier.
// - High sync on: switch to low waits for high carrier falling edge.
// - High sync off: switch away from high at once, spurs allowed.
// - High select: 0100 PWM, 0011 reference clock, 0010 pin two, 0001 pin one.
// - High select codes 0101 to 1111 connect nothing.
// - Low pin-disable bit set stops the low carrier source driving its pin.
// - Low polarity bit inverts the selected low carrier.
// - Low sync on: switch to high waits for low carrier falling edge.
// - Low sync off: switch away from low at once, spurs allowed.
// - Low select: 0000 ground, 0001 pin one, 0011 reference clock, 0100 PWM.
// - Low select 0010 and 0101 to 1111 connect nothing.
// - Bit 4 of both carrier registers reads zero, ignores writes.
// - Modulation one picks the high carrier, zero the low carrier.
module dsm_carrier (
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic carrier_input_pin_one, // Carrier pin one
  input wire logic carrier_input_pin_two, // Carrier pin two
  input wire logic reference_clock_signal, // Reference clock source
  input wire logic capture_compare_pwm_output, // PWM source
  input wire logic pwm_mode_active, // PWM source is in PWM mode
  input wire logic modulation_pin, // Modulation input pin
  output logic modulated_out, // Modulated output level
  output logic modulated_out_oe, // Output pin enable
  output logic modulated_slew_limit, // Slew limit on the output pin
  output logic pwm_pin_disable, // Stop PWM driving its own pin
  output logic refclk_pin_disable // Stop reference clock driving its pin
);
  import dsm_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Field layout inside the 8-bit registers
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 3;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 32;
  localparam int LANE_PAD = WORD_W - BYTE_W;
  localparam int SYNC_STAGES = 2;
  localparam int N_PINS = 5;

  // Slot of each asynchronous source in the synchroniser vector
  localparam int PIN_CIN1 = 0;
  localparam int PIN_CIN2 = 1;
  localparam int PIN_REF = 2;
  localparam int PIN_PWM = 3;
  localparam int PIN_MOD = 4;

  // Slot of each register in the one-hot address decode
  localparam int DEC_CON = 0;
  localparam int DEC_SRC = 1;
  localparam int DEC_CARH = 2;
  localparam int DEC_CARL = 3;
  localparam int N_REGS = 4;

  //////////////////////////////////////////////////////////////////////
  // All state of the block, registered as one word
  typedef struct packed {
    logic [BYTE_W-1:0] con;
    logic [BYTE_W-1:0] src;
    logic [BYTE_W-1:0] carh;
    logic [BYTE_W-1:0] carl;
    logic [SYNC_STAGES-1:0][N_PINS-1:0] pin_s;
    logic hi_prev;
    logic lo_prev;
    dsm_state_type st;
    logic [WORD_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic out;
    logic oe;
    logic slr;
    logic pwm_dis;
    logic ref_dis;
  } dsm_regs_type;

  dsm_regs_type s_r;
  dsm_regs_type s_nxt;

  //////////////////////////////////////////////////////////////////////
  // Carrier mux; unused codes give a quiet zero
  function automatic logic carrier_pick(
    input logic [SEL_MSB:SEL_LSB] sel,
    input logic allow_cin2,
    input logic cin1,
    input logic cin2,
    input logic refc,
    input logic pwm,
    input logic pwm_on
  );
    logic v;
    v = 1'b0;
    case (sel)
      DSM_SEL_VSS: begin
        v = 1'b0;
      end
      DSM_SEL_CIN1: begin
        v = cin1;
      end
      DSM_SEL_CIN2: begin
        v = allow_cin2 & cin2;
      end
      DSM_SEL_REFCLK: begin
        v = refc;
      end
      // PWM output counts only while its source runs in PWM mode
      DSM_SEL_PWM: begin
        v = pwm & pwm_on;
      end
      default: begin
        v = 1'b0;
      end
    endcase
    return v;
  endfunction

  // Address decode, one bit per register, zero for a hole in the map
  function automatic logic [N_REGS-1:0] reg_decode(
    input logic [11:0] addr
  );
    logic [N_REGS-1:0] hit_v;
    hit_v = '0;
    case (addr)
      DSM_OFF_MODCTL: hit_v[DEC_CON] = 1'b1;
      DSM_OFF_MODSRC: hit_v[DEC_SRC] = 1'b1;
      DSM_OFF_CARH: hit_v[DEC_CARH] = 1'b1;
      DSM_OFF_CARL: hit_v[DEC_CARL] = 1'b1;
      default: hit_v = '0;
    endcase
    return hit_v;
  endfunction

  // Source pin is released when its disable bit is set and it is selected
  function automatic logic pin_off(
    input logic [BYTE_W-1:0] ctl,
    input logic [SEL_MSB:SEL_LSB] code
  );
    return ctl[DSM_BIT_PINDIS] && (ctl[SEL_MSB:SEL_LSB] == code);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Combinational helpers
  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] pin_q;
  logic hi_raw;
  logic lo_raw;
  logic hi_car;
  logic lo_car;
  logic hi_fall;
  logic lo_fall;
  logic mod_sig;
  logic want_high;
  logic mixed;
  logic [N_REGS-1:0] dec;
  logic [BYTE_W-1:0] rd_byte;
  logic [BYTE_W-1:0] wb;
  logic setup_ph;
  logic wr_take;

  //////////////////////////////////////////////////////////////////////
  // Pin sources gathered into one vector for the synchroniser
  assign pin_raw[PIN_CIN1] = carrier_input_pin_one;
  assign pin_raw[PIN_CIN2] = carrier_input_pin_two;
  assign pin_raw[PIN_REF] = reference_clock_signal;
  assign pin_raw[PIN_PWM] = capture_compare_pwm_output;
  assign pin_raw[PIN_MOD] = modulation_pin;
  // Only the second stage is read; the first may still be settling
  assign pin_q = s_r.pin_s[SYNC_STAGES-1];

  //////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    // Two-flop synchroniser for every pin source
    s_nxt.pin_s = {s_r.pin_s[0], pin_raw};

    hi_raw = carrier_pick(
      s_r.carh[SEL_MSB:SEL_LSB],
      1'b1,
      pin_q[PIN_CIN1],
      pin_q[PIN_CIN2],
      pin_q[PIN_REF],
      pin_q[PIN_PWM],
      pwm_mode_active
    );
    lo_raw = carrier_pick(
      s_r.carl[SEL_MSB:SEL_LSB],
      1'b0,
      pin_q[PIN_CIN1],
      pin_q[PIN_CIN2],
      pin_q[PIN_REF],
      pin_q[PIN_PWM],
      pwm_mode_active
    );

    hi_car = hi_raw ^ s_r.carh[DSM_BIT_INV];
    lo_car = lo_raw ^ s_r.carl[DSM_BIT_INV];
    s_nxt.hi_prev = hi_car;
    s_nxt.lo_prev = lo_car;
    // Falling edge as seen after polarity
    hi_fall = s_r.hi_prev & ~hi_car;
    lo_fall = s_r.lo_prev & ~lo_car;

    // Modulation source
    case (s_r.src[SEL_MSB:SEL_LSB])
      DSM_MS_BIT: begin
        mod_sig = s_r.con[DSM_BIT_MBIT];
      end
      DSM_MS_PIN: begin
        mod_sig = pin_q[PIN_MOD];
      end
      DSM_MS_PWM: begin
        mod_sig = pin_q[PIN_PWM] & pwm_mode_active;
      end
      default: begin
        mod_sig = 1'b0;
      end
    endcase
    want_high = mod_sig;

    // A synced side holds until its own carrier falls
    case (s_r.st)
      DSM_ST_HIGH: begin
        if (!want_high && (!s_r.carh[DSM_BIT_SYNC] || hi_fall)) begin
          s_nxt.st = DSM_ST_LOW;
        end
      end
      DSM_ST_LOW: begin
        if (want_high && (!s_r.carl[DSM_BIT_SYNC] || lo_fall)) begin
          s_nxt.st = DSM_ST_HIGH;
        end
      end
      default: s_nxt.st = DSM_ST_LOW;
    endcase

    // Output follows the side chosen this cycle
    mixed = (s_nxt.st == DSM_ST_HIGH) ? hi_car : lo_car;
    // Disabled module drives low regardless of polarity
    if (s_r.con[DSM_BIT_EN]) begin
      s_nxt.out = mixed ^ s_r.con[DSM_BIT_OPOL];
    end else begin
      s_nxt.out = 1'b0;
    end
    s_nxt.oe = s_r.con[DSM_BIT_EN] & s_r.con[DSM_BIT_OE];
    s_nxt.slr = s_r.con[DSM_BIT_SLR];

    s_nxt.pwm_dis = pin_off(s_r.carh, DSM_SEL_PWM) |
                    pin_off(s_r.carl, DSM_SEL_PWM) |
                    pin_off(s_r.src, DSM_MS_PWM);
    s_nxt.ref_dis = pin_off(s_r.carh, DSM_SEL_REFCLK) |
                    pin_off(s_r.carl, DSM_SEL_REFCLK);

    //////////////////////////////////////////////////////////////////////
    // APB slave, answers in the access cycle
    setup_ph = psel & ~penable;
    dec = reg_decode(paddr);
    wb = pwdata[BYTE_W-1:0];
    rd_byte = '0;
    if (dec[DEC_CON]) begin
      rd_byte = {s_r.con[DSM_BIT_EN:DSM_BIT_OPOL], s_r.out, 2'b00, s_r.con[DSM_BIT_MBIT]};
    end
    if (dec[DEC_SRC]) begin
      rd_byte = s_r.src;
    end
    if (dec[DEC_CARH]) begin
      rd_byte = s_r.carh & DSM_CAR_WMASK;
    end
    if (dec[DEC_CARL]) begin
      rd_byte = s_r.carl & DSM_CAR_WMASK;
    end
    s_nxt.pready = setup_ph;
    s_nxt.pslverr = setup_ph & ~(|dec);
    if (setup_ph && !pwrite) begin
      s_nxt.prdata = {{LANE_PAD{1'b0}}, rd_byte};
    end

    // Write lands at the access edge only
    wr_take = psel & penable & pwrite & s_r.pready;
    if (wr_take && dec[DEC_CON]) begin
      s_nxt.con = wb & DSM_CON_WMASK;
    end
    if (wr_take && dec[DEC_SRC]) begin
      s_nxt.src = wb & DSM_SRC_WMASK;
    end
    if (wr_take && dec[DEC_CARH]) begin
      s_nxt.carh = wb & DSM_CAR_WMASK;
    end
    if (wr_take && dec[DEC_CARL]) begin
      s_nxt.carl = wb & DSM_CAR_WMASK;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register; reset loads the register defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.con <= DSM_CON_RST;
      s_r.src <= DSM_SRC_RST;
      s_r.carh <= DSM_CAR_RST;
      s_r.carl <= DSM_CAR_RST;
      s_r.st <= DSM_ST_LOW;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign modulated_out = s_r.out;
  assign modulated_out_oe = s_r.oe;
  assign modulated_slew_limit = s_r.slr;
  assign pwm_pin_disable = s_r.pwm_dis;
  assign refclk_pin_disable = s_r.ref_dis;
endmodule // dsm_carrier

// ==== pkg/dsm_pkg.sv ====
// Purpose: constants and types for the carrier select and sync block
// Assumes: APB slave with 32-bit data, registers 8 bits wide in the low lane
// Notes: offsets are byte addresses, one aligned word per register
package dsm_pkg;
  localparam logic [11:0] DSM_OFF_MODCTL = 12'h000;
  localparam logic [11:0] DSM_OFF_MODSRC = 12'h004;
  localparam logic [11:0] DSM_OFF_CARH = 12'h008;
  localparam logic [11:0] DSM_OFF_CARL = 12'h00C;
  localparam int DSM_BIT_PINDIS = 7;
  localparam int DSM_BIT_INV = 6;
  localparam int DSM_BIT_SYNC = 5;
  localparam int DSM_BIT_EN = 7;
  localparam int DSM_BIT_OE = 6;
  localparam int DSM_BIT_SLR = 5;
  localparam int DSM_BIT_OPOL = 4;
  localparam int DSM_BIT_OUT = 3;
  localparam int DSM_BIT_MBIT = 0;
  localparam logic [7:0] DSM_CAR_WMASK = 8'hEF;
  localparam logic [7:0] DSM_CON_WMASK = 8'hF1;
  localparam logic [7:0] DSM_SRC_WMASK = 8'h8F;
  localparam logic [7:0] DSM_CON_RST = 8'h20;
  localparam logic [7:0] DSM_CAR_RST = 8'h00;
  localparam logic [7:0] DSM_SRC_RST = 8'h00;
  localparam logic [3:0] DSM_SEL_VSS = 4'h0;
  localparam logic [3:0] DSM_SEL_CIN1 = 4'h1;
  localparam logic [3:0] DSM_SEL_CIN2 = 4'h2;
  localparam logic [3:0] DSM_SEL_REFCLK = 4'h3;
  localparam logic [3:0] DSM_SEL_PWM = 4'h4;
  localparam logic [3:0] DSM_MS_BIT = 4'h0;
  localparam logic [3:0] DSM_MS_PIN = 4'h1;
  localparam logic [3:0] DSM_MS_PWM = 4'h2;
  typedef enum logic [1:0] {
    DSM_ST_LOW = 2'b01,
    DSM_ST_HIGH = 2'b10
  } dsm_state_type;
endpackage

// ==== tb/dsm_sources.sv ====
// Purpose: carrier and modulation sources
// Assumes: levels chosen by the bench
// Notes: one flop, like a peripheral output
`timescale 1ns/100ps
module dsm_sources (
  input wire logic pclk, // Clock
  input wire logic [4:0] lvl, // Wanted levels
  output logic [4:0] src // Source outputs
);
  always_ff @(posedge pclk) begin
    src <= lvl;
  end
endmodule // dsm_sources

// ==== tb/dsm_carrier_properties.sv ====
// Purpose: APB port checks
// Assumes: zero wait slave
// Notes: register side only
`timescale 1ns/100ps
module dsm_carrier_properties (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] prdata, // Data
  input wire logic pready, // Ready
  input wire logic pslverr // Error
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("long ready");
  access_ready_a: assert property (psel && penable |-> pready)
    else $error("wait state");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("stray error");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  bit4_zero_a: assert property (pready && !pwrite && paddr[3] |-> !prdata[4])
    else $error("bit 4 set");
  unmapped_err_a: assert property (pready && paddr > 12'h00C |-> pslverr)
    else $error("no error");
  mapped_ok_a: assert property (pready && paddr <= 12'h00C && paddr[1:0] == 2'b00
    |-> !pslverr)
    else $error("false error");
endmodule // dsm_carrier_properties
bind dsm_carrier dsm_carrier_properties i_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr);

// ==== tb/dsm_carrier_tb.sv ====
// Purpose: self-checking bench
// Assumes: zero wait APB, sources from dsm_sources
// Notes: one tally task ends the run
`timescale 1ns/100ps
module dsm_carrier_tb;
  import dsm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic mout, pwm_dis, ref_dis, oe, slr, pwm_on = 1'b1;
  logic [4:0] lvl = 5'h00, src;
  int error_cnt = 0, check_count = 0, cyc = 0;
  always #10 pclk = ~pclk;
  dsm_sources i_dsm_sources (.pclk, .lvl, .src);
  dsm_carrier i_dsm_carrier (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .carrier_input_pin_one(src[0]),
    .carrier_input_pin_two(src[1]), .reference_clock_signal(src[2]),
    .capture_compare_pwm_output(src[3]), .pwm_mode_active(pwm_on), .modulation_pin(src[4]),
    .modulated_out(mout), .modulated_out_oe(oe), .modulated_slew_limit(slr),
    .pwm_pin_disable(pwm_dis), .refclk_pin_disable(ref_dis));
  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic regs_check();
    apb(1'b0, DSM_OFF_MODCTL, 8'h00);
    chk(rd, 32'h20);
    chk({30'h0, oe, slr}, 32'h1);
    apb(1'b0, DSM_OFF_CARH, 8'h00);
    chk(rd, 32'h00);
    apb(1'b1, DSM_OFF_CARL, 8'hFF);
    apb(1'b0, DSM_OFF_CARL, 8'h00);
    chk(rd, 32'hEF);
    apb(1'b0, 12'h010, 8'h00);
    chk({31'h0, perr}, 32'h1);
  endtask
  task automatic sel_sweep(input logic hi);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, hi ? DSM_OFF_CARH : DSM_OFF_CARL, 8'(c));
      for (int k = 0; k < 4; k++) begin
        lvl <= 5'(1 << k);
        wt(6);
        chk({31'h0, mout}, {31'h0, c == k + 1 && (hi || k != 1)});
      end
    end
  endtask
  task automatic inv_pin();
    lvl <= 5'h00;
    apb(1'b1, DSM_OFF_CARL, 8'hC3);
    wt(6);
    chk({31'h0, mout}, 32'h1);
    chk({30'h0, pwm_dis, ref_dis}, 32'h1);
    apb(1'b1, DSM_OFF_CARL, 8'h03);
    apb(1'b1, DSM_OFF_MODCTL, 8'hC1);
    apb(1'b1, DSM_OFF_CARH, 8'hC4);
    wt(6);
    chk({31'h0, mout}, 32'h1);
    chk({30'h0, pwm_dis, ref_dis}, 32'h2);
  endtask
  // Held side shows only while waiting for its falling edge
  task automatic sync_run(input logic [7:0] ch, input logic [7:0] cl, input logic [3:0] l,
    input logic m, input logic e, input int k);
    apb(1'b1, DSM_OFF_CARH, ch);
    apb(1'b1, DSM_OFF_CARL, cl);
    lvl <= {1'b0, l};
    apb(1'b1, DSM_OFF_MODCTL, {7'h60, ~m});
    wt(8);
    apb(1'b1, DSM_OFF_MODCTL, {7'h60, m});
    wt(6);
    chk({31'h0, mout}, {31'h0, e});
    lvl[k] <= 1'b1;
    wt(4);
    lvl[k] <= 1'b0;
    wt(6);
    chk({31'h0, mout}, 32'h1);
  endtask
  // PWM gating, pin as modulation source, output polarity and pin controls
  task automatic misc_run();
    apb(1'b1, DSM_OFF_CARH, 8'h04);
    apb(1'b1, DSM_OFF_MODSRC, 8'h01);
    lvl <= 5'h18;
    pwm_on <= 1'b0;
    wt(6);
    chk({31'h0, mout}, 32'h0);
    pwm_on <= 1'b1;
    wt(6);
    chk({31'h0, mout}, 32'h1);
    lvl <= 5'h08;
    wt(6);
    chk({31'h0, mout}, 32'h0);
    apb(1'b1, DSM_OFF_MODCTL, 8'hD0);
    wt(2);
    chk({29'h0, mout, oe, slr}, 32'h6);
    apb(1'b1, DSM_OFF_MODCTL, 8'h20);
    wt(2);
    chk({29'h0, mout, oe, slr}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    wt(12);
    presetn <= 1'b1;
    regs_check();
    apb(1'b1, DSM_OFF_CARH, 8'h00);
    apb(1'b1, DSM_OFF_CARL, 8'h00);
    apb(1'b1, DSM_OFF_MODCTL, 8'hC1);
    sel_sweep(1'b1);
    apb(1'b1, DSM_OFF_MODCTL, 8'hC0);
    sel_sweep(1'b0);
    inv_pin();
    sync_run(8'h21, 8'h03, 4'h4, 1'b0, 1'b0, 0);
    sync_run(8'h01, 8'h03, 4'h4, 1'b0, 1'b1, 0);
    sync_run(8'h01, 8'h23, 4'h1, 1'b1, 1'b0, 2);
    sync_run(8'h01, 8'h03, 4'h1, 1'b1, 1'b1, 2);
    misc_run();
    tally_and_finish();
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
endmodule // dsm_carrier_tb
